// file: rtl/smch_top.sv
// Self-monitoring command handler with APB task-file registers
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module smch_top (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Live wear counters
	input wire smch_pkg::smch_wear_t wear,
	// Nonvolatile enable storage
	input wire logic nv_en_in,
	output logic nv_en_out,
	output logic nv_wr,
	// Interrupt request line
	output logic intrq
);

	smch_pkg::smch_state_t state_reg;
	smch_pkg::smch_state_t state_next;
	logic [7:0] feat_reg;
	logic [7:0] seccnt_reg;
	logic [7:0] cyl_lo_reg;
	logic [7:0] cyl_hi_reg;
	logic [7:0] devhead_reg;
	logic [7:0] cmd_reg;
	logic [7:0] err_reg;
	logic [15:0] limit_reg;
	logic en_reg;
	logic loaded_reg;
	logic thr_reg;
	logic [7:0] word_reg;
	logic [7:0] sum_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic nv_wr_reg;
	logic intrq_reg;

	// Builds one byte of the data or thresholds sector from its index
	function automatic logic [7:0] sector_byte(input logic thr, input logic [8:0] idx,
		input smch_pkg::smch_wear_t w, input logic [7:0] csum);
		logic [8:0] rel;
		logic [4:0] slot;
		logic [3:0] ofs;
		logic [7:0] id;
		logic [31:0] raw;
		logic [7:0] b;
		rel = idx - smch_pkg::OFS_ATTR;
		slot = 5'(rel / smch_pkg::SLOT_BYTES);
		ofs = 4'(rel % smch_pkg::SLOT_BYTES);
		id = 8'h00;
		b = 8'h00;
		if (slot < smch_pkg::NUM_ATTR) begin
			id = smch_pkg::ATTR_IDS[slot*8 +: 8];
		end
		raw = 32'h0000_0000;
		if (id == smch_pkg::ID_SPARE) begin
			raw = {16'h0000, w.spare};
		end else if (id == smch_pkg::ID_AVG_ERASE) begin
			raw = w.erase;
		end
		if (idx == 9'h000) begin
			b = smch_pkg::STRUCT_VER[7:0];
		end else if (idx == 9'h001) begin
			b = smch_pkg::STRUCT_VER[15:8];
		end else if (idx == smch_pkg::OFS_CSUM) begin
			b = csum;
		end else if (idx < smch_pkg::OFS_ATTR_END) begin
			if (id == 8'h00) begin
				b = 8'h00;
			end else if (thr) begin
				case (ofs)
					4'h0: b = id;
					4'h1: b = smch_pkg::ATTR_THRS[slot*8 +: 8];
					default: b = 8'h00;
				endcase
			end else begin
				case (ofs)
					4'h0: b = id;
					4'h1: b = {7'h00, smch_pkg::ATTR_OLD[slot]};
					4'h3: b = smch_pkg::VALUE_FULL;
					4'h4: b = smch_pkg::VALUE_FULL;
					4'h5: b = raw[7:0];
					4'h6: b = raw[15:8];
					4'h7: b = raw[23:16];
					4'h8: b = raw[31:24];
					default: b = 8'h00;
				endcase
			end
		end else if (!thr) begin
			// Offline, self-test, logging bytes stay zero
			if (idx == smch_pkg::OFS_CAPS) begin
				b = smch_pkg::CAPS_WORD[7:0];
			end else if (idx == smch_pkg::OFS_CAPS + 9'h001) begin
				b = smch_pkg::CAPS_WORD[15:8];
			end else if (idx == smch_pkg::OFS_SHORT_POLL || idx == smch_pkg::OFS_EXT_POLL) begin
				b = smch_pkg::POLL_TIME;
			end else if (idx == smch_pkg::OFS_SPARE) begin
				b = w.spare[7:0];
			end else if (idx == smch_pkg::OFS_SPARE + 9'h001) begin
				b = w.spare[15:8];
			end else if (idx == smch_pkg::OFS_ERASE) begin
				b = w.erase[7:0];
			end else if (idx == smch_pkg::OFS_ERASE + 9'h001) begin
				b = w.erase[15:8];
			end else if (idx == smch_pkg::OFS_ERASE + 9'h002) begin
				b = w.erase[23:16];
			end else if (idx == smch_pkg::OFS_ERASE + 9'h003) begin
				b = w.erase[31:24];
			end
		end
		return b;
	endfunction

	// APB decode
	wire setup_w = psel & ~penable;
	wire done_w = psel & penable & pready_reg;
	wire wr_fire = done_w & pwrite;
	wire rd_fire = done_w & ~pwrite;
	wire hit_feat = paddr == smch_pkg::ADDR_FEATURE;
	wire hit_seccnt = paddr == smch_pkg::ADDR_SECCNT;
	wire hit_cyl_lo = paddr == smch_pkg::ADDR_CYL_LO;
	wire hit_cyl_hi = paddr == smch_pkg::ADDR_CYL_HI;
	wire hit_devhead = paddr == smch_pkg::ADDR_DEVHEAD;
	wire hit_cmd = paddr == smch_pkg::ADDR_COMMAND;
	wire hit_status = paddr == smch_pkg::ADDR_STATUS;
	wire hit_err = paddr == smch_pkg::ADDR_ERROR;
	wire hit_data = paddr == smch_pkg::ADDR_DATA;
	wire hit_limit = paddr == smch_pkg::ADDR_LIMIT;
	wire hit_wear = paddr == smch_pkg::ADDR_WEAR;
	wire mapped = hit_feat | hit_seccnt | hit_cyl_lo | hit_cyl_hi | hit_devhead | hit_cmd |
		hit_status | hit_err | hit_data | hit_limit | hit_wear;
	// Task file is locked while a command runs, as on a busy drive
	wire tf_wr = wr_fire & (state_reg == smch_pkg::S_IDLE) & loaded_reg;
	wire cmd_start = tf_wr & hit_cmd;
	wire pop = rd_fire & hit_data & (state_reg == smch_pkg::S_XFER);

	// Command decode
	wire in_exec = state_reg == smch_pkg::S_EXEC;
	wire is_mon = cmd_reg == smch_pkg::OP_MONITOR;
	wire feat_known = (feat_reg == smch_pkg::FEAT_READ) | (feat_reg == smch_pkg::FEAT_THRESH) |
		(feat_reg == smch_pkg::FEAT_AUTOSAVE) | (feat_reg == smch_pkg::FEAT_SAVE) |
		(feat_reg == smch_pkg::FEAT_OFFLINE) | (feat_reg == smch_pkg::FEAT_ENABLE) |
		(feat_reg == smch_pkg::FEAT_DISABLE) | (feat_reg == smch_pkg::FEAT_STATUS);
	wire abort_w = ~is_mon | ~feat_known |
		(~en_reg & (feat_reg != smch_pkg::FEAT_ENABLE));
	wire exec_ok = in_exec & ~abort_w;
	wire is_xfer = (feat_reg == smch_pkg::FEAT_READ) | (feat_reg == smch_pkg::FEAT_THRESH);
	wire do_enable = exec_ok & (feat_reg == smch_pkg::FEAT_ENABLE);
	wire do_disable = exec_ok & (feat_reg == smch_pkg::FEAT_DISABLE);
	wire do_status = exec_ok & (feat_reg == smch_pkg::FEAT_STATUS);
	wire spare_low = wear.spare < limit_reg;
	wire irq_set = in_exec;
	wire irq_clr = (rd_fire & hit_status) | cmd_start;

	// Sector data word; checksum closes the running sum of bytes 0 to 510
	wire [7:0] byte_lo = sector_byte(thr_reg, {word_reg, 1'b0}, wear, 8'h00);
	wire [7:0] csum_w = 8'h00 - sum_reg - byte_lo;
	wire [7:0] byte_hi = sector_byte(thr_reg, {word_reg, 1'b1}, wear, csum_w);
	wire [31:0] data_word = (state_reg == smch_pkg::S_XFER) ?
		{16'h0000, byte_hi, byte_lo} : 32'h0000_0000;

	smch_pkg::smch_status_t status_w;
	assign status_w.en = en_reg;
	assign status_w.intrq = intrq_reg;
	assign status_w.err = err_reg != smch_pkg::ERR_NONE;
	assign status_w.drq = state_reg == smch_pkg::S_XFER;
	assign status_w.drdy = loaded_reg;
	assign status_w.bsy = in_exec | ~loaded_reg;

	wire [31:0] rd_mux = hit_feat ? {24'h000000, feat_reg} :
		hit_seccnt ? {24'h000000, seccnt_reg} :
		hit_cyl_lo ? {24'h000000, cyl_lo_reg} :
		hit_cyl_hi ? {24'h000000, cyl_hi_reg} :
		hit_devhead ? {24'h000000, devhead_reg} :
		hit_cmd ? {24'h000000, cmd_reg} :
		hit_status ? {26'h0, status_w} :
		hit_err ? {24'h000000, err_reg} :
		hit_data ? data_word :
		hit_limit ? {16'h0000, limit_reg} :
		hit_wear ? {16'h0000, wear.spare} : 32'h0000_0000;

	// Command sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			smch_pkg::S_IDLE: begin
				if (cmd_start) begin
					state_next = smch_pkg::S_EXEC;
				end
			end
			smch_pkg::S_EXEC: begin
				// One busy cycle for every command; save attributes has nothing to store
				if (~abort_w & is_xfer) begin
					state_next = smch_pkg::S_XFER;
				end else begin
					state_next = smch_pkg::S_IDLE;
				end
			end
			smch_pkg::S_XFER: begin
				if (pop && word_reg == smch_pkg::LAST_WORD) begin
					state_next = smch_pkg::S_IDLE;
				end
			end
			default: state_next = smch_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg <= smch_pkg::S_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Task file registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			feat_reg <= 8'h00;
			seccnt_reg <= 8'h00;
			devhead_reg <= 8'h00;
			cmd_reg <= 8'h00;
			limit_reg <= smch_pkg::LIMIT_RST;
		end else if (tf_wr) begin
			if (hit_feat) feat_reg <= pwdata[7:0];
			if (hit_seccnt) seccnt_reg <= pwdata[7:0];
			if (hit_devhead) devhead_reg <= pwdata[7:0];
			if (hit_cmd) cmd_reg <= pwdata[7:0];
			if (hit_limit) limit_reg <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cyl_lo_reg <= 8'h00;
			cyl_hi_reg <= 8'h00;
		end else if (do_status) begin
			cyl_lo_reg <= spare_low ? smch_pkg::ALERT_LO : smch_pkg::KEY_LO;
			cyl_hi_reg <= spare_low ? smch_pkg::ALERT_HI : smch_pkg::KEY_HI;
		end else if (tf_wr) begin
			if (hit_cyl_lo) cyl_lo_reg <= pwdata[7:0];
			if (hit_cyl_hi) cyl_hi_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			err_reg <= smch_pkg::ERR_NONE;
		end else if (in_exec) begin
			err_reg <= abort_w ? smch_pkg::ERR_ABORT : smch_pkg::ERR_NONE;
		end
	end

	// Enable state: taken from storage after reset, written back on every enable or disable command that is not aborted
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			loaded_reg <= 1'b0;
			en_reg <= 1'b0;
			nv_wr_reg <= 1'b0;
		end else begin
			loaded_reg <= 1'b1;
			nv_wr_reg <= do_enable | do_disable;
			if (!loaded_reg) begin
				en_reg <= nv_en_in;
			end else if (do_enable) begin
				en_reg <= 1'b1;
			end else if (do_disable) begin
				en_reg <= 1'b0;
			end
		end
	end

	// Sector streaming
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			word_reg <= 8'h00;
			sum_reg <= 8'h00;
			thr_reg <= 1'b0;
		end else if (exec_ok & is_xfer) begin
			word_reg <= 8'h00;
			sum_reg <= 8'h00;
			thr_reg <= feat_reg == smch_pkg::FEAT_THRESH;
		end else if (pop) begin
			word_reg <= word_reg + 8'h01;
			sum_reg <= sum_reg + prdata_reg[7:0] + prdata_reg[15:8];
		end
	end

	// Interrupt: a completion in the same cycle as a status read wins
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			intrq_reg <= 1'b0;
		end else begin
			intrq_reg <= irq_set | (intrq_reg & ~irq_clr);
		end
	end

	// APB answer: data latched in setup, ready in the first access cycle
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= setup_w;
			if (setup_w) begin
				prdata_reg <= (mapped & ~pwrite) ? rd_mux : 32'h0000_0000;
				pslverr_reg <= ~mapped;
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign nv_en_out = en_reg;
	assign nv_wr = nv_wr_reg;
	assign intrq = intrq_reg;

	AST_UNKNOWN_ABORT: assert property (@(posedge clk_sys) disable iff (!nrst)
		in_exec & is_mon & ~feat_known |=> err_reg == smch_pkg::ERR_ABORT &&
		state_reg == smch_pkg::S_IDLE && intrq_reg)
		else $error("unknown feature not aborted");
	AST_DISABLED_ABORT: assert property (@(posedge clk_sys) disable iff (!nrst)
		in_exec & ~en_reg & (feat_reg != smch_pkg::FEAT_ENABLE) |=>
		err_reg == smch_pkg::ERR_ABORT && !status_w.drq)
		else $error("command ran while disabled");
	AST_ENABLE_SET: assert property (@(posedge clk_sys) disable iff (!nrst)
		in_exec & is_mon & (feat_reg == smch_pkg::FEAT_ENABLE) |=> en_reg && nv_wr)
		else $error("enable did not take effect");
	AST_NV_WRITE: assert property (@(posedge clk_sys) disable iff (!nrst)
		do_disable |=> !nv_en_out && nv_wr ##1 !nv_wr)
		else $error("disable not written to storage");
	AST_ALERT: assert property (@(posedge clk_sys) disable iff (!nrst)
		do_status & spare_low |=> cyl_lo_reg == smch_pkg::ALERT_LO &&
		cyl_hi_reg == smch_pkg::ALERT_HI)
		else $error("threshold alert not reported");
	AST_NO_ALERT: assert property (@(posedge clk_sys) disable iff (!nrst)
		do_status & ~spare_low |=> cyl_lo_reg == smch_pkg::KEY_LO &&
		cyl_hi_reg == smch_pkg::KEY_HI)
		else $error("good status not reported");
	AST_NOOP_DONE: assert property (@(posedge clk_sys) disable iff (!nrst)
		exec_ok & ((feat_reg == smch_pkg::FEAT_AUTOSAVE) | (feat_reg == smch_pkg::FEAT_OFFLINE))
		|=> state_reg == smch_pkg::S_IDLE && en_reg == $past(en_reg) && !nv_wr)
		else $error("no-operation changed state");
	AST_SAVE_IRQ: assert property (@(posedge clk_sys) disable iff (!nrst)
		cmd_start & (pwdata[7:0] == smch_pkg::OP_MONITOR) ##1
		(en_reg && feat_reg == smch_pkg::FEAT_SAVE) |-> status_w.bsy && !intrq_reg
		##1 !status_w.bsy && intrq_reg)
		else $error("save attributes busy and interrupt out of order");
	AST_ONE_SECTOR: assert property (@(posedge clk_sys) disable iff (!nrst)
		pop && word_reg == smch_pkg::LAST_WORD |=> state_reg == smch_pkg::S_IDLE)
		else $error("transfer did not end after one sector");
	AST_VERSION: assert property (@(posedge clk_sys) disable iff (!nrst)
		status_w.drq && word_reg == 8'h00 |-> byte_lo == 8'h00 && byte_hi == 8'h01)
		else $error("structure version wrong");

endmodule // smch_top

// file: common/smch_pkg.sv
// Constants and types of the self-monitoring command handler
package smch_pkg;
	// Command opcode, keys and status answers
	localparam logic [7:0] OP_MONITOR = 8'hB0;
	localparam logic [7:0] KEY_HI = 8'hC2;
	localparam logic [7:0] KEY_LO = 8'h4F;
	localparam logic [7:0] ALERT_HI = 8'h2C;
	localparam logic [7:0] ALERT_LO = 8'hF4;
	// Feature codes
	localparam logic [7:0] FEAT_READ = 8'hD0;
	localparam logic [7:0] FEAT_THRESH = 8'hD1;
	localparam logic [7:0] FEAT_AUTOSAVE = 8'hD2;
	localparam logic [7:0] FEAT_SAVE = 8'hD3;
	localparam logic [7:0] FEAT_OFFLINE = 8'hD4;
	localparam logic [7:0] FEAT_ENABLE = 8'hD8;
	localparam logic [7:0] FEAT_DISABLE = 8'hD9;
	localparam logic [7:0] FEAT_STATUS = 8'hDA;
	// Error register values for an aborted and for a completed command
	localparam logic [7:0] ERR_ABORT = 8'h04;
	localparam logic [7:0] ERR_NONE = 8'h00;
	// Sector layout
	localparam logic [15:0] STRUCT_VER = 16'h0100;
	localparam logic [15:0] CAPS_WORD = 16'h0200;
	localparam logic [7:0] POLL_TIME = 8'h01;
	localparam logic [7:0] VALUE_FULL = 8'h64;
	localparam logic [8:0] OFS_ATTR = 9'h002;
	localparam logic [8:0] OFS_ATTR_END = 9'h16A;
	localparam logic [8:0] SLOT_BYTES = 9'h00C;
	localparam logic [4:0] NUM_ATTR = 5'h17;
	localparam logic [8:0] OFS_CAPS = 9'h170;
	localparam logic [8:0] OFS_SHORT_POLL = 9'h174;
	localparam logic [8:0] OFS_EXT_POLL = 9'h175;
	localparam logic [8:0] OFS_SPARE = 9'h1EA;
	localparam logic [8:0] OFS_ERASE = 9'h1EC;
	localparam logic [8:0] OFS_CSUM = 9'h1FF;
	localparam logic [7:0] LAST_WORD = 8'hFF;
	// Attribute table, slot 0 in the lowest byte
	localparam logic [183:0] ATTR_IDS = {8'hF4, 8'hF3, 8'hF2, 8'hF1, 8'hD7, 8'hC7, 8'hC6,
		8'hC4, 8'hC3, 8'hC2, 8'hC0, 8'hA9, 8'hA7, 8'hA6, 8'hA5, 8'hA4, 8'hA3, 8'hA1,
		8'hA0, 8'h0C, 8'h09, 8'h05, 8'h01};
	localparam logic [183:0] ATTR_THRS = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h32, 8'h32,
		8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h32, 8'h32, 8'h00, 8'h00, 8'h19,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [22:0] ATTR_OLD = 23'h000420;
	localparam logic [7:0] ID_SPARE = 8'hA1;
	localparam logic [7:0] ID_AVG_ERASE = 8'hA7;
	// APB register byte offsets
	localparam logic [11:0] ADDR_FEATURE = 12'h000;
	localparam logic [11:0] ADDR_SECCNT = 12'h004;
	localparam logic [11:0] ADDR_CYL_LO = 12'h008;
	localparam logic [11:0] ADDR_CYL_HI = 12'h00C;
	localparam logic [11:0] ADDR_DEVHEAD = 12'h010;
	localparam logic [11:0] ADDR_COMMAND = 12'h014;
	localparam logic [11:0] ADDR_STATUS = 12'h018;
	localparam logic [11:0] ADDR_ERROR = 12'h01C;
	localparam logic [11:0] ADDR_DATA = 12'h020;
	localparam logic [11:0] ADDR_LIMIT = 12'h024;
	localparam logic [11:0] ADDR_WEAR = 12'h028;
	localparam logic [15:0] LIMIT_RST = 16'h0010;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_EXEC = 2'b01,
		S_XFER = 2'b10
	} smch_state_t;
	typedef struct packed {
		logic en;
		logic intrq;
		logic err;
		logic drq;
		logic drdy;
		logic bsy;
	} smch_status_t;
	typedef struct packed {
		logic [15:0] spare;
		logic [31:0] erase;
	} smch_wear_t;
endpackage

// file: bench/smch_host_bfm.sv
// Host-side APB master model issuing task-file commands
`timescale 1ns/1ns
module smch_host_bfm (
	// Clock
	input wire logic clk_sys,
	// APB master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	logic hung = 1'b0;
	logic [31:0] rdata;
	logic rerr;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// One transfer; request held until pready is sampled high, for at most 16 access cycles
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) hung <= 1'b1;
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released data does not keep its last value
		pwdata <= ~d;
	endtask
	// Every subcommand carries the opcode, both keys and the fixed device/head bits
	task automatic issue(input logic [7:0] feat, input logic [7:0] sc);
		xfer(1'b1, smch_pkg::ADDR_FEATURE, {24'h000000, feat});
		xfer(1'b1, smch_pkg::ADDR_SECCNT, {24'h000000, sc});
		xfer(1'b1, smch_pkg::ADDR_CYL_LO, {24'h000000, smch_pkg::KEY_LO});
		xfer(1'b1, smch_pkg::ADDR_CYL_HI, {24'h000000, smch_pkg::KEY_HI});
		xfer(1'b1, smch_pkg::ADDR_DEVHEAD, 32'h000000E0);
		xfer(1'b1, smch_pkg::ADDR_COMMAND, {24'h000000, smch_pkg::OP_MONITOR});
	endtask
endmodule // smch_host_bfm

// file: bench/tb_smch_top.sv
// Self-checking testbench of the self-monitoring command handler
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_smch_top;
	logic clk_sys;
	logic nrst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	smch_pkg::smch_wear_t wear;
	logic nv_en_out;
	logic nv_wr;
	logic intrq;
	logic nv_cell = 1'b0;
	int fails = 0;
	int checks_done = 0;
	logic [7:0] sec [512];
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	smch_top i_smch_top (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wear(wear), .nv_en_in(nv_cell), .nv_en_out(nv_en_out),
		.nv_wr(nv_wr), .intrq(intrq));
	smch_host_bfm i_smch_host_bfm (.clk_sys(clk_sys), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	// Nonvolatile cell keeps whatever enable the device last saved
	always @(posedge clk_sys) if (nv_wr === 1'b1) nv_cell <= nv_en_out;
	always @(posedge clk_sys) if (i_smch_host_bfm.hung === 1'b1) begin
		fails++;
		conclude();
	end
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		i_smch_host_bfm.xfer(1'b0, a, 32'h00000000);
		d = i_smch_host_bfm.rdata;
	endtask
	task automatic cmd(input logic [7:0] feat, input logic [7:0] sc, input logic [7:0] exp_err);
		i_smch_host_bfm.issue(feat, sc);
		done_is(exp_err);
	endtask
	// Waits for the completion interrupt, then checks the error register
	task automatic done_is(input logic [7:0] exp_err);
		int n;
		logic [31:0] d;
		@(posedge clk_sys);
		n = 0;
		while (intrq !== 1'b1 && n < 8) begin
			@(posedge clk_sys);
			n++;
		end
		`CHK(intrq, 1'b1)
		rd(smch_pkg::ADDR_ERROR, d);
		`CHK(d[7:0], exp_err)
	endtask
	task automatic get_sector(input logic [7:0] feat);
		logic [31:0] d;
		logic [7:0] sum;
		cmd(feat, 8'h00, smch_pkg::ERR_NONE);
		sum = 8'h00;
		for (int i = 0; i < 256; i++) begin
			rd(smch_pkg::ADDR_DATA, d);
			sec[2*i] = d[7:0];
			sec[2*i+1] = d[15:8];
			sum = sum + d[7:0] + d[15:8];
		end
		`CHK(sum, 8'h00)
		rd(smch_pkg::ADDR_STATUS, d);
		`CHK(d[5:0], 6'h32)
	endtask
	task automatic t_disabled;
		logic [31:0] d;
		`CHK(nv_en_out, 1'b0)
		cmd(smch_pkg::FEAT_STATUS, 8'h00, smch_pkg::ERR_ABORT);
		cmd(smch_pkg::FEAT_READ, 8'h00, smch_pkg::ERR_ABORT);
		rd(smch_pkg::ADDR_STATUS, d);
		`CHK(d[5:0], 6'h1A)
		rd(smch_pkg::ADDR_STATUS, d);
		`CHK(d[4], 1'b0)
	endtask
	// Enable must survive a reset because storage feeds it back
	task automatic t_enable;
		cmd(smch_pkg::FEAT_ENABLE, 8'h00, smch_pkg::ERR_NONE);
		`CHK(nv_en_out, 1'b1)
		`CHK(nv_cell, 1'b1)
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		`CHK(nv_en_out, 1'b1)
	endtask
	task automatic t_codes;
		logic [7:0] bad [4] = '{8'hD5, 8'hD7, 8'hDB, 8'h00};
		cmd(smch_pkg::FEAT_AUTOSAVE, 8'hF1, smch_pkg::ERR_NONE);
		cmd(smch_pkg::FEAT_AUTOSAVE, 8'h00, smch_pkg::ERR_NONE);
		cmd(smch_pkg::FEAT_SAVE, 8'h00, smch_pkg::ERR_NONE);
		cmd(smch_pkg::FEAT_OFFLINE, 8'h00, smch_pkg::ERR_NONE);
		foreach (bad[i]) cmd(bad[i], 8'h00, smch_pkg::ERR_ABORT);
		`CHK(nv_en_out, 1'b1)
	endtask
	task automatic status_is(input logic [15:0] lim, input logic [15:0] exp);
		logic [31:0] lo;
		logic [31:0] hi;
		i_smch_host_bfm.xfer(1'b1, smch_pkg::ADDR_LIMIT, {16'h0000, lim});
		cmd(smch_pkg::FEAT_STATUS, 8'h00, smch_pkg::ERR_NONE);
		rd(smch_pkg::ADDR_CYL_HI, hi);
		rd(smch_pkg::ADDR_CYL_LO, lo);
		`CHK({hi[7:0], lo[7:0]}, exp)
	endtask
	task automatic t_data(input logic [15:0] spare, input logic [31:0] erase);
		logic [31:0] d;
		@(posedge clk_sys);
		wear <= {spare, erase};
		get_sector(smch_pkg::FEAT_READ);
		rd(smch_pkg::ADDR_WEAR, d);
		`CHK(d, {16'h0000, spare})
		`CHK({sec[1], sec[0]}, 16'h0100)
		`CHK({sec[2], sec[5], sec[6]}, 24'h016464)
		`CHK({sec[63], sec[62]}, 16'h01A1)
		`CHK({sec[70], sec[69], sec[68], sec[67]}, {16'h0000, spare})
		`CHK({sec[362], sec[363], sec[367], sec[370]}, 32'h00000000)
		`CHK({sec[369], sec[368]}, 16'h0200)
		`CHK({sec[372], sec[373], sec[374]}, 24'h010100)
		`CHK({sec[491], sec[490]}, spare)
		`CHK({sec[495], sec[494], sec[493], sec[492]}, erase)
		`CHK({sec[266], sec[278], sec[290]}, 24'hF40000)
	endtask
	task automatic t_thresh;
		get_sector(smch_pkg::FEAT_THRESH);
		`CHK({sec[1], sec[0]}, 16'h0100)
		`CHK({sec[62], sec[63], sec[122], sec[123]}, 32'hA119A701)
		`CHK({sec[2], sec[3], sec[124], sec[362]}, 32'h01000000)
	endtask
	task automatic t_unmapped;
		i_smch_host_bfm.xfer(1'b0, 12'h02C, 32'h00000000);
		`CHK({i_smch_host_bfm.rerr, i_smch_host_bfm.rdata}, 33'h100000000)
	endtask
	// A valid feature under a foreign opcode must still end aborted
	task automatic t_opcode;
		i_smch_host_bfm.xfer(1'b1, smch_pkg::ADDR_FEATURE, {24'h000000, smch_pkg::FEAT_OFFLINE});
		i_smch_host_bfm.xfer(1'b1, smch_pkg::ADDR_COMMAND, 32'h000000EC);
		done_is(smch_pkg::ERR_ABORT);
	endtask
	task automatic t_disable;
		cmd(smch_pkg::FEAT_DISABLE, 8'h00, smch_pkg::ERR_NONE);
		`CHK({nv_en_out, nv_cell}, 2'b00)
		cmd(smch_pkg::FEAT_SAVE, 8'h00, smch_pkg::ERR_ABORT);
	endtask
	initial begin
		nrst = 1'b0;
		wear = {16'h0123, 32'h89ABCDEF};
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		t_disabled();
		t_enable();
		t_codes();
		t_opcode();
		status_is(16'h0010, 16'hC24F);
		status_is(16'h0124, 16'h2CF4);
		status_is(16'h0123, 16'hC24F);
		t_data(16'h0123, 32'h89ABCDEF);
		t_data(16'h0456, 32'h00010203);
		t_thresh();
		t_unmapped();
		t_disable();
		conclude();
	end
	initial begin
		repeat (100000) @(posedge clk_sys);
		fails++;
		conclude();
	end
endmodule // tb_smch_top
